//--- rtl/instr_subset_exec.sv
// Execution unit for a subset of an 8-bit core instruction set.
// Assumes one instruction word per clock while instr_valid is high,
// and combinational data memory read data for the operand address.
// Return stack, flags and table latch belong to the core.
// Clock enable low freezes every register.

`timescale 1ns/1ps
`default_nettype none
module instr_subset_exec
   import instr_subset_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 clk_en,

   // Configuration
   input  wire logic                 ext_instr_enable,

   // Instruction stream
   input  wire logic                 instr_valid,
   input  wire logic [INSTR_W-1:0]   instr,
   output logic                      instr_ready,

   // Core state inputs
   input  wire logic                 ovf_flag,
   input  wire logic [3:0]           bank_select_reg,
   input  wire logic [PC_W-1:0]      return_stack_top,
   input  wire logic [DATA_W-1:0]    table_latch,
   input  wire logic                 tptr_load,
   input  wire logic [TPTR_W-1:0]    tptr_load_val,
   input  wire logic                 pc_load,
   input  wire logic [PC_W-1:0]      pc_load_val,

   // Data memory port
   output logic      [PTR_W-1:0]     dmem_addr,
   input  wire logic [DATA_W-1:0]    dmem_rdata,
   output logic                      dmem_we,
   output logic      [DATA_W-1:0]    dmem_wdata,
   output logic                      dmem_indexed,

   // Return stack
   output logic                      stack_pop,

   // Architectural state
   output logic      [PC_W-1:0]      pc,
   output logic      [PTR_W-1:0]     ptr0,
   output logic      [PTR_W-1:0]     ptr1,
   output logic      [PTR_W-1:0]     indirect_pointer_two,
   output logic      [TPTR_W-1:0]    table_pointer,
   output logic      [HOLD_N*DATA_W-1:0] hold_flat,
   output logic                      illegal_op
);

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // Sequencer state
   seq_state_e state_r;
   seq_state_e state_nxt;

   // Decode results and fields
   logic dec_toggle;
   logic dec_bov;
   logic dec_table_write_op;
   logic dec_ptradd;
   logic dec_addret;
   logic dec_ptr_legal;
   logic issue;
   logic [1:0] ptr_sel;
   logic [LIT6_W-1:0] lit6;
   logic [PTR_W-1:0]  lit_ext;
   logic bov_taken;
   logic dec_known;

   // Ready only in the execute state;
   // the core holds a refused word.
   // The literal is unsigned.
   assign instr_ready = (state_r == ST_EXEC);
   assign issue       = instr_valid & instr_ready & clk_en;
   assign ptr_sel     = instr[PTR_SEL_LSB +: 2];
   assign lit6        = instr[LIT6_W-1:0];
   assign lit_ext     = {{(PTR_W-LIT6_W){1'b0}}, lit6}; // Unsigned literal

   // Select three is add-and-return,
   // not a fourth pointer.
   // Opcode matching; extended forms only with extension enabled
   always_comb begin
      dec_toggle = (instr & MASK_TOGGLE) == OPC_TOGGLE;
      dec_bov    = (instr & MASK_BOV) == OPC_BOV;
      dec_table_write_op  = (instr & MASK_TABLE_WRITE_OP) == OPC_TABLE_WRITE_OP;
      dec_ptradd = ext_instr_enable
                   && ((instr & MASK_PTRADD) == OPC_PTRADD);
      dec_addret = dec_ptradd && (ptr_sel == PTR_SEL_RETURN);
      dec_ptr_legal = dec_ptradd && !dec_addret;
   end

   // Branch condition from the overflow status
   // Overflow clear: one cycle, next word
   assign bov_taken = dec_bov & ovf_flag;

   // Supported pattern; anything else is unknown
   assign dec_known = dec_toggle | dec_bov | dec_table_write_op | dec_ptradd;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Taken branch and add-and-return drop the prefetched word;
   // a table write uses its second cycle for the holding write.
   // Ready is low in either extra cycle.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_EXEC: begin
            if (issue) begin
               if (bov_taken || dec_addret) begin
                  state_nxt = ST_FLUSH;
               end else if (dec_table_write_op) begin
                  state_nxt = ST_TWRITE;
               end
            end
         end
         ST_FLUSH: begin
            if (clk_en) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_TWRITE: begin
            if (clk_en) begin
               state_nxt = ST_EXEC;
            end
         end
         default: begin
            state_nxt = ST_EXEC;
         end
      endcase
   end

   // State holds while clk_en is low
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_EXEC;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Program counter
   // ---------------------------------------------------------------
   // Program counter and targets
   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] br_off;
   logic [PC_W-1:0] pc_seq;
   logic [PC_W-1:0] pc_branch;

   // Twice the signed offset, sign extended
   assign br_off = {{(PC_W-9){instr[7]}}, instr[7:0], 1'b0};

   // Next word; the step covers the prefetch
   assign pc_seq    = pc_r + PC_STEP;
   assign pc_branch = pc_seq + br_off;

   // Direct load wins over an issued word
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc_r <= '0;
      end else if (clk_en) begin
         if (pc_load) begin
            pc_r <= pc_load_val;
         end else if (issue) begin
            if (bov_taken) begin
               pc_r <= pc_branch;
            end else if (dec_addret) begin
               pc_r <= return_stack_top;
            end else begin
               pc_r <= pc_seq;
            end
         end
      end
   end

   // Program counter output
   assign pc = pc_r;

   // Return stack pop on add-and-return
   // The core pops on this pulse
   assign stack_pop = issue & dec_addret;

   // ---------------------------------------------------------------
   // Indirect pointers; no status flags are touched
   // ---------------------------------------------------------------
   // Indirect pointers zero to two
   logic [PTR_W-1:0] ptr_r [3];

   // Select three folds onto pointer two;
   // no pointer moves with the extension off.
   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++) begin : g_ptr
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               ptr_r[gp] <= '0;
            end else if (issue) begin
               if (dec_ptr_legal && ptr_sel == 2'(gp)) begin
                  ptr_r[gp] <= ptr_r[gp] + lit_ext;
               end else if (dec_addret && PTR_SEL_TWO == 2'(gp)) begin
                  ptr_r[gp] <= ptr_r[gp] + lit_ext;
               end
            end
         end
      end
   endgenerate

   // Pointers straight from registers
   assign ptr0                 = ptr_r[0];
   assign ptr1                 = ptr_r[1];
   assign indirect_pointer_two = ptr_r[2];

   // Unknown pattern flag, registered
   // Holds until the next issued word
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         illegal_op <= 1'b0;
      end else if (issue) begin
         illegal_op <= !dec_known;
      end
   end

   // ---------------------------------------------------------------
   // Bit toggle
   // ---------------------------------------------------------------
   // Toggle results
   logic [DATA_W-1:0] tog_data;
   logic [PTR_W-1:0]  tog_addr;
   logic              tog_idx;

   // Read, flip and write-back all fall
   // in the issuing cycle, with no stall.
   bit_toggle_unit u_toggle (
      .file_addr            (instr[7:0]),
      .bit_sel              (instr[BIT_SEL_LSB +: 3]),
      .access_bit           (instr[ACCESS_BIT]),
      .ext_instr_enable     (ext_instr_enable),
      .bank_select_reg      (bank_select_reg),
      .indirect_pointer_two (ptr_r[2]),
      .rd_data              (dmem_rdata),
      .wr_data              (tog_data),
      .eff_addr             (tog_addr),
      .indexed_mode         (tog_idx)
   );

   // Write back in the same instruction cycle
   // Strobe pulses only while taken
   assign dmem_addr    = tog_addr;
   assign dmem_indexed = tog_idx;
   assign dmem_we      = issue & dec_toggle;
   assign dmem_wdata   = tog_data;

   // ---------------------------------------------------------------
   // Table write
   // ---------------------------------------------------------------
   logic tw_start;
   logic tw_commit;

   // Pointer moves at the issuing edge; the holding register
   // is written a cycle later from the latch as it stands then.
   assign tw_start  = issue & dec_table_write_op;
   assign tw_commit = (state_r == ST_TWRITE);

   table_write_unit u_twrite (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .clk_en       (clk_en),
      .start        (tw_start),
      .commit       (tw_commit),
      .mode         (instr[1:0]),
      .table_latch  (table_latch),
      .ptr_load     (tptr_load),
      .ptr_load_val (tptr_load_val),
      .table_pointer(table_pointer),
      .hold_flat    (hold_flat)
   );

endmodule : instr_subset_exec
`default_nettype wire

//--- rtl/instr_subset_pkg.sv
// Package for the instruction subset execution unit.
// Holds opcode patterns, field positions, widths and state codes.
// Assumes a 16-bit instruction word presented one per instruction cycle.
package instr_subset_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int INSTR_W    = 16;
   localparam int DATA_W     = 8;
   localparam int PC_W       = 21;
   localparam int TPTR_W     = 21;
   localparam int PTR_W      = 12;
   localparam int HOLD_N     = 8;
   localparam int HOLD_IDX_W = 3;

   // ---------------------------------------------------------------
   // Opcode patterns (value under mask)
   // ---------------------------------------------------------------
   localparam logic [15:0] MASK_TOGGLE   = 16'hF000;
   localparam logic [15:0] OPC_TOGGLE    = 16'h7000;
   localparam logic [15:0] MASK_BOV      = 16'hFF00;
   localparam logic [15:0] OPC_BOV       = 16'hE400;
   localparam logic [15:0] MASK_TABLE_WRITE_OP    = 16'hFFFC;
   localparam logic [15:0] OPC_TABLE_WRITE_OP     = 16'h000C;
   localparam logic [15:0] MASK_PTRADD   = 16'hFF00;
   localparam logic [15:0] OPC_PTRADD    = 16'hE800;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_SEL_LSB  = 9;
   localparam int ACCESS_BIT   = 8;
   localparam int PTR_SEL_LSB  = 6;
   localparam int LIT6_W       = 6;
   localparam logic [1:0] PTR_SEL_RETURN = 2'h3;
   localparam logic [1:0] PTR_SEL_TWO    = 2'h2;

   // Highest file address reached through indexed literal-offset mode
   localparam logic [7:0] IDX_FILE_MAX = 8'h5F;

   // Table write pointer modes
   localparam logic [1:0] TW_KEEP     = 2'h0;
   localparam logic [1:0] TW_POST_INC = 2'h1;
   localparam logic [1:0] TW_POST_DEC = 2'h2;
   localparam logic [1:0] TW_PRE_INC  = 2'h3;

   // Program counter step for one instruction word
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_EXEC   = 2'b00,
      ST_FLUSH  = 2'b01,
      ST_TWRITE = 2'b10
   } seq_state_e;

endpackage : instr_subset_pkg

//--- rtl/table_write_unit.sv
// Table write unit: eight holding registers filled from the table latch.
// Assumes start pulses come from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module table_write_unit
   import instr_subset_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 clk_en,
   // Control from sequencer
   input  wire logic                 start,
   input  wire logic                 commit,
   input  wire logic [1:0]           mode,
   input  wire logic [DATA_W-1:0]    table_latch,
   // Pointer load
   input  wire logic                 ptr_load,
   input  wire logic [TPTR_W-1:0]    ptr_load_val,
   // State
   output logic      [TPTR_W-1:0]    table_pointer,
   output logic      [HOLD_N*DATA_W-1:0] hold_flat
);

   logic [TPTR_W-1:0]    tptr_r;
   logic [HOLD_IDX_W-1:0] widx_r;
   logic [DATA_W-1:0]    hold_r [HOLD_N];

   // ---------------------------------------------------------------
   // Pointer update and write index capture
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tptr_r <= '0;
         widx_r <= '0;
      end else if (clk_en) begin
         if (ptr_load) begin
            tptr_r <= ptr_load_val;
         end else if (start) begin
            // Index used is the pre-increment or current pointer
            case (mode)
               TW_KEEP: begin
                  widx_r <= tptr_r[HOLD_IDX_W-1:0];
               end
               TW_POST_INC: begin
                  widx_r <= tptr_r[HOLD_IDX_W-1:0];
                  tptr_r <= tptr_r + 21'h1;
               end
               TW_POST_DEC: begin
                  widx_r <= tptr_r[HOLD_IDX_W-1:0];
                  tptr_r <= tptr_r - 21'h1;
               end
               TW_PRE_INC: begin
                  widx_r <= HOLD_IDX_W'(tptr_r + 21'h1);
                  tptr_r <= tptr_r + 21'h1;
               end
               default: begin
                  widx_r <= tptr_r[HOLD_IDX_W-1:0];
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Holding registers, written in the second cycle
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < HOLD_N; gi++) begin : g_hold
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               hold_r[gi] <= '0;
            end else if (clk_en && commit && widx_r == HOLD_IDX_W'(gi)) begin
               hold_r[gi] <= table_latch;
            end
         end
         assign hold_flat[gi*DATA_W +: DATA_W] = hold_r[gi];
      end
   endgenerate

   assign table_pointer = tptr_r;

endmodule : table_write_unit
`default_nettype wire

//--- rtl/bit_toggle_unit.sv
// Bit toggle datapath and operand address formation.
// Assumes the data byte is read combinationally from the core's memory.
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_unit
   import instr_subset_pkg::*;
(
   // Operand fields
   input  wire logic [7:0]        file_addr,
   input  wire logic [2:0]        bit_sel,
   input  wire logic              access_bit,
   input  wire logic              ext_instr_enable,
   input  wire logic [3:0]        bank_select_reg,
   input  wire logic [PTR_W-1:0]  indirect_pointer_two,
   // Data
   input  wire logic [DATA_W-1:0] rd_data,
   output logic      [DATA_W-1:0] wr_data,
   output logic      [PTR_W-1:0]  eff_addr,
   output logic                   indexed_mode
);

   // Indexed literal offset only with extension on and low file address
   assign indexed_mode = ~access_bit & ext_instr_enable
                         & (file_addr <= IDX_FILE_MAX);

   // Effective address: indexed, banked or access bank
   always_comb begin
      if (indexed_mode) begin
         eff_addr = indirect_pointer_two + {4'h0, file_addr};
      end else if (access_bit) begin
         eff_addr = {bank_select_reg, file_addr};
      end else if (file_addr[7]) begin
         eff_addr = {4'hF, file_addr};
      end else begin
         eff_addr = {4'h0, file_addr};
      end
   end

   // Invert only the selected bit
   assign wr_data = rd_data ^ (DATA_W'(1) << bit_sel);

endmodule : bit_toggle_unit
`default_nettype wire

//--- test/instr_subset_exec_checker.sv
// Checker for the instruction subset execution unit.
// Assumes it is bound to instr_subset_exec and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module instr_subset_exec_checker
   import instr_subset_pkg::*;
(
   // Clock, reset and stream
   input wire logic               clk,
   input wire logic               sys_rst,
   input wire logic               clk_en,
   input wire logic               ext_instr_enable,
   input wire logic               instr_valid,
   input wire logic [INSTR_W-1:0] instr,
   input wire logic               instr_ready,
   // Core state inputs
   input wire logic               ovf_flag,
   input wire logic               tptr_load,
   input wire logic               pc_load,
   input wire logic [PC_W-1:0]    return_stack_top,
   input wire logic [DATA_W-1:0]  dmem_rdata,
   // Observed outputs
   input wire logic [PTR_W-1:0]   dmem_addr,
   input wire logic               dmem_we,
   input wire logic [DATA_W-1:0]  dmem_wdata,
   input wire logic               dmem_indexed,
   input wire logic               stack_pop,
   input wire logic [PC_W-1:0]    pc,
   input wire logic [PTR_W-1:0]   indirect_pointer_two,
   input wire logic [TPTR_W-1:0]  table_pointer,
   input wire logic               illegal_op
);
   // ---------------------------------------------------------------
   // Decode of the accepted word
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || !clk_en);
   logic               iss, is_tog, is_bov, is_tw, is_add, is_ret;
   logic [15:0]        instr_r;
   logic [TPTR_W-1:0]  tw_delta;
   assign iss    = instr_valid && instr_ready && clk_en && !pc_load && !tptr_load;
   assign is_tog = iss && ((instr & MASK_TOGGLE) == OPC_TOGGLE);
   assign is_bov = iss && ((instr & MASK_BOV) == OPC_BOV);
   assign is_tw  = iss && ((instr & MASK_TABLE_WRITE_OP) == OPC_TABLE_WRITE_OP);
   assign is_add = iss && ((instr & MASK_PTRADD) == OPC_PTRADD);
   assign is_ret = is_add && ext_instr_enable && instr[7:6] == PTR_SEL_RETURN;
   assign tw_delta = (instr_r[1:0] == TW_POST_DEC) ? 21'h1FFFFF :
                     (instr_r[1:0] == TW_KEEP) ? 21'h000000 : 21'h000001;
   // Word of the previous cycle, accepted or not, for the follow-up checks
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) instr_r <= 16'h0000;
      else         instr_r <= instr;
   end
   sequence s_flush;
      !instr_ready ##1 instr_ready;
   endsequence
   a_toggle_write: assert property (is_tog |-> dmem_we &&
      dmem_wdata == (dmem_rdata ^ (8'h01 << instr[11:9]))) else $error("toggle data");
   a_index_mode: assert property (is_tog && ext_instr_enable && !instr[8] &&
      instr[7:0] <= IDX_FILE_MAX |-> dmem_indexed &&
      dmem_addr == indirect_pointer_two + {4'h0, instr[7:0]}) else $error("index addr");
   a_bov_taken: assert property (is_bov && ovf_flag |=>
      pc == $past(pc) + PC_STEP + {{12{instr_r[7]}}, instr_r[7:0], 1'b0} ##0 s_flush)
      else $error("branch taken");
   a_bov_untaken: assert property (is_bov && !ovf_flag |=>
      pc == $past(pc) + PC_STEP && instr_ready) else $error("branch untaken");
   a_ret_form: assert property (is_ret |-> stack_pop ##1
      (pc == $past(return_stack_top) && !instr_ready &&
      indirect_pointer_two == $past(indirect_pointer_two) + {6'h00, instr_r[5:0]}) ##1
      instr_ready) else $error("add and return");
   a_ext_off: assert property (is_add && !ext_instr_enable |=>
      illegal_op && $stable(indirect_pointer_two)) else $error("ext off");
   a_tw_flush: assert property (is_tw |=> s_flush) else $error("table write cycles");
   a_tw_ptr: assert property (is_tw |=>
      table_pointer == $past(table_pointer) + tw_delta) else $error("table pointer");
endmodule : instr_subset_exec_checker

bind instr_subset_exec instr_subset_exec_checker u_chk (.clk(clk), .sys_rst(sys_rst),
   .clk_en(clk_en), .ext_instr_enable(ext_instr_enable), .instr_valid(instr_valid),
   .instr(instr), .instr_ready(instr_ready), .ovf_flag(ovf_flag), .tptr_load(tptr_load),
   .pc_load(pc_load), .return_stack_top(return_stack_top), .dmem_rdata(dmem_rdata),
   .dmem_addr(dmem_addr), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
   .dmem_indexed(dmem_indexed), .stack_pop(stack_pop), .pc(pc),
   .indirect_pointer_two(indirect_pointer_two), .table_pointer(table_pointer),
   .illegal_op(illegal_op));
`default_nettype wire

//--- test/test_core_instr_subset_exec.sv
// Self-checking bench for the instruction subset execution unit.
// Assumes the package constants and one word per cycle on instr.
`timescale 1ns/1ps
`default_nettype none
module test_core_instr_subset_exec
   import instr_subset_pkg::*;
;
   typedef struct packed {
      logic [PC_W-1:0]          pc;
      logic [PTR_W-1:0]         p0, p1, p2;
      logic [TPTR_W-1:0]        tp;
      logic [HOLD_N*DATA_W-1:0] hold;
      logic                     ill;
   } state_s;
   logic clk, sys_rst, clk_en, ext_instr_enable, instr_valid, instr_ready, ovf_flag;
   logic tptr_load, pc_load, dmem_we, dmem_indexed, stack_pop, illegal_op, pend;
   logic [INSTR_W-1:0]        instr;
   logic [3:0]                bank_select_reg;
   logic [PC_W-1:0]           return_stack_top, pc_load_val, pc;
   logic [DATA_W-1:0]         table_latch, dmem_rdata, dmem_wdata;
   logic [TPTR_W-1:0]         tptr_load_val, table_pointer;
   logic [PTR_W-1:0]          dmem_addr, ptr0, ptr1, indirect_pointer_two;
   logic [HOLD_N*DATA_W-1:0]  hold_flat;
   state_s m, e;
   state_s q[$];
   int n_fail, tests_run, i;

   instr_subset_exec DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .ext_instr_enable(ext_instr_enable), .instr_valid(instr_valid), .instr(instr),
      .instr_ready(instr_ready), .ovf_flag(ovf_flag), .bank_select_reg(bank_select_reg),
      .return_stack_top(return_stack_top), .table_latch(table_latch), .tptr_load(tptr_load),
      .tptr_load_val(tptr_load_val), .pc_load(pc_load), .pc_load_val(pc_load_val),
      .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .dmem_we(dmem_we),
      .dmem_wdata(dmem_wdata), .dmem_indexed(dmem_indexed), .stack_pop(stack_pop),
      .pc(pc), .ptr0(ptr0), .ptr1(ptr1), .indirect_pointer_two(indirect_pointer_two),
      .table_pointer(table_pointer), .hold_flat(hold_flat), .illegal_op(illegal_op));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // Next falling edge at which the unit accepts a word
   task automatic wait_slot;
      int g;
      g = 0;
      @(negedge clk);
      while (instr_ready !== 1'b1 && g < 20) begin
         g++;
         @(negedge clk);
      end
   endtask : wait_slot

   // Issue one word, note its expected state, check the same-cycle strobes
   task automatic issue(input logic [15:0] w, input logic ov, input logic ex);
      logic [11:0] ea, k;
      logic        tog, ret;
      wait_slot();
      {instr_valid, instr, ovf_flag, ext_instr_enable} = {1'b1, w, ov, ex};
      dmem_rdata = 8'($urandom);
      table_latch = 8'($urandom);
      bank_select_reg = 4'($urandom);
      return_stack_top = 21'($urandom);
      tog = (w & MASK_TOGGLE) == OPC_TOGGLE;
      ret = ex && (w & 16'hFFC0) == 16'hE8C0;
      k = {6'h00, w[5:0]};
      ea = {w[7] ? 4'hF : 4'h0, w[7:0]};
      if (w[8]) ea = {bank_select_reg, w[7:0]};
      else if (ex && w[7:0] <= IDX_FILE_MAX) ea = m.p2 + {4'h0, w[7:0]};
      m.ill = 1'b0;
      m.pc = m.pc + PC_STEP;
      if ((w & MASK_BOV) == OPC_BOV) begin
         if (ov) m.pc = m.pc + {{12{w[7]}}, w[7:0], 1'b0};
      end else if ((w & MASK_TABLE_WRITE_OP) == OPC_TABLE_WRITE_OP) begin
         if (w[1:0] == TW_PRE_INC) m.tp = m.tp + 21'h000001;
         m.hold[8*m.tp[2:0] +: 8] = table_latch;
         if (w[1:0] == TW_POST_INC) m.tp = m.tp + 21'h000001;
         if (w[1:0] == TW_POST_DEC) m.tp = m.tp - 21'h000001;
      end else if ((w & MASK_PTRADD) == OPC_PTRADD && ex) begin
         if (w[7:6] == 2'h0) m.p0 = m.p0 + k;
         else if (w[7:6] == 2'h1) m.p1 = m.p1 + k;
         else m.p2 = m.p2 + k;
         if (ret) m.pc = return_stack_top;
      end else if (!tog) m.ill = 1'b1;
      q.push_back(m);
      #2;
      check(64'(dmem_we), 64'(tog));
      check(64'(stack_pop), 64'(ret));
      if (tog) check(64'(dmem_wdata), 64'(dmem_rdata ^ (8'h01 << w[11:9])));
      if (tog) check(64'(dmem_addr), 64'(ea));
      if (tog) check(64'(dmem_indexed), 64'(ex && !w[8] && w[7:0] <= IDX_FILE_MAX));
   endtask : issue

   // Direct load of table pointer and program counter
   task automatic load(input logic [20:0] tp, input logic [20:0] pv);
      wait_slot();
      {instr_valid, tptr_load, tptr_load_val, pc_load, pc_load_val} = {2'b01, tp, 1'b1, pv};
      m.tp = tp;
      m.pc = pv;
      q.push_back(m);
      @(negedge clk);
      {tptr_load, pc_load} = 2'b00;
   endtask : load

   // ---------------------------------------------------------------
   // Clock, watchdog and result monitor
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
   // Compare the oldest note once the unit is ready again
   always @(negedge clk) begin
      #1;
      if (pend && instr_ready === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         pend = 1'b0;
         check(64'(pc), 64'(e.pc));
         check(64'({ptr0, ptr1, indirect_pointer_two}), 64'({e.p0, e.p1, e.p2}));
         check(64'(table_pointer), 64'(e.tp));
         check(hold_flat, e.hold);
         check(64'(illegal_op), 64'(e.ill));
      end
      if ((instr_valid && instr_ready && clk_en) || pc_load) pend = 1'b1;
   end

   // Main sequence
   initial begin
      {sys_rst, clk_en, ext_instr_enable, instr_valid, ovf_flag, tptr_load, pc_load} = 7'h60;
      {instr, bank_select_reg, return_stack_top, table_latch} = '0;
      {tptr_load_val, pc_load_val, dmem_rdata, pend, n_fail, tests_run} = '0;
      m = '0;
      void'($urandom(77));
      repeat (10) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      // Pointer adds on selectors zero to two, largest literal first
      for (i = 0; i < 3; i++) issue(16'hE83F | 16'(i << 6), 1'b0, 1'b1);
      for (i = 0; i < 6; i++) issue(16'hE800 | 16'($urandom % 192), 1'b0, 1'b1);
      // Toggle each bit position, both extension settings, indexed boundary
      for (i = 0; i < 32; i++) issue(16'h7000 | 16'(i % 8) << 9 | 16'($urandom % 512), 1'b0, i[4]);
      issue(16'h705F, 1'b0, 1'b1);
      issue(16'h7060, 1'b0, 1'b1);
      // Overflow branch with extreme and random offsets, back to back
      issue(16'hE480, 1'b1, 1'b0);
      issue(16'hE47F, 1'b1, 1'b0);
      for (i = 0; i < 6; i++) issue(16'hE400 | 16'($urandom % 256), i[0], 1'b0);
      // Add and return, then refused and unknown words
      for (i = 0; i < 3; i++) issue(16'hE8C0 | 16'($urandom % 64), 1'b0, 1'b1);
      issue(16'hE805, 1'b0, 1'b0);
      issue(16'hE8C1, 1'b0, 1'b0);
      issue(16'hFFFF, 1'b0, 1'b1);
      // Table writes in every mode, wrapping the pointer range both ways
      load(21'h1FFFFE, 21'($urandom));
      for (i = 0; i < 16; i++) issue(16'h000C | 16'(i < 8 ? i % 4 : $urandom % 4), 1'b0, 1'b0);
      // Freeze a table write in its commit cycle
      issue(16'h000D, 1'b0, 1'b0);
      @(negedge clk);
      clk_en = 1'b0;
      repeat (3) @(negedge clk);
      check(64'(instr_ready), 64'h0);
      clk_en = 1'b1;
      wait_slot();
      instr_valid = 1'b0;
      repeat (4) @(negedge clk);
      check(64'(q.size()), 64'h0);
      tally_and_finish();
   end
endmodule : test_core_instr_subset_exec
`default_nettype wire
